// ===== hdl/vsw_config_regs.sv
// Configuration register bank of the three-way video link switch
`timescale 1ns/100ps
`default_nettype none
module vsw_config_regs #(
  parameter longint PULSE_CYCLES = vsw_pkg::VSW_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Decoded serial register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  output logic                    reg_rvalid,
  // Strap pins
  input  wire vsw_pkg::vsw_strap_t strap,
  // Effective configuration
  output vsw_pkg::vsw_cfg_t       cfg
);
  import vsw_pkg::*;

  localparam int CNT_W = $clog2(PULSE_CYCLES + 1);

  typedef struct packed {
    vsw_regs_t  regs;
    logic       serial_seen;
    logic [1:0] prev_src;
    logic [7:0] rdata;
    logic       rvalid;
    vsw_cfg_t   cfg;
  } vsw_state_t;

  vsw_state_t st_r;
  vsw_state_t st_nxt;
  logic       pulse_start;
  logic       pulse_busy;

  // Side source decode, one bit per source
  function automatic logic [2:0] vsw_side_route(input logic       en,
                                                input logic [1:0] sel);
    logic [2:0] r;
    r = 3'h0;
    if (en)
    begin
      unique case (sel)
        VSW_SRC_A: r = 3'h1;
        VSW_SRC_B: r = 3'h2;
        VSW_SRC_C: r = 3'h4;
        default:   r = 3'h0;
      endcase
    end
    return r;
  endfunction

  // Strap image of the register set
  function automatic vsw_regs_t vsw_strap_image(input vsw_strap_t s,
                                                input vsw_regs_t  cur);
    vsw_regs_t r;
    r = cur;
    r.fast = 8'h00;
    r.fast[VSW_ENABLE_BIT] = s.strap_fast_enable;
    r.fast[VSW_SRC_LSB +: 2] = s.strap_source_select;
    r.side = 8'h00;
    r.side[VSW_ENABLE_BIT] = 1'b1;
    r.side[VSW_SRC_LSB +: 2] = s.strap_source_select;
    r.iterm = VSW_MASK_ITERM;
    r.pulse_ab = 8'h00;
    r.pulse_c = 8'h00;
    r.eq_ab = {8{s.strap_eq_level}};
    r.eq_c = {4'h0, {4{s.strap_eq_level}}};
    r.drv[VSW_EMPH_LSB +: 2] = s.strap_emphasis_pins;
    r.drv[VSW_CUR_BIT] = s.strap_current_level;
    return r;
  endfunction

  // Masked register read
  function automatic logic [7:0] vsw_read(input vsw_regs_t  r,
                                          input logic [7:0] a);
    logic [7:0] d;
    d = VSW_READ_UNMAPPED;
    unique case (a)
      VSW_ADDR_FAST:     d = r.fast & VSW_MASK_MODE;
      VSW_ADDR_SIDE:     d = r.side & VSW_MASK_MODE;
      VSW_ADDR_ITERM:    d = r.iterm & VSW_MASK_ITERM;
      VSW_ADDR_PULSE_AB: d = r.pulse_ab & VSW_MASK_FULL;
      VSW_ADDR_PULSE_C:  d = r.pulse_c & VSW_MASK_NIBBLE;
      VSW_ADDR_EQ_AB:    d = r.eq_ab & VSW_MASK_FULL;
      VSW_ADDR_EQ_C:     d = r.eq_c & VSW_MASK_NIBBLE;
      VSW_ADDR_DRV:      d = r.drv & VSW_MASK_DRV;
      default:           d = VSW_READ_UNMAPPED;
    endcase
    return d;
  endfunction

  // Masked register write
  function automatic vsw_regs_t vsw_write(input vsw_regs_t  r,
                                          input logic [7:0] a,
                                          input logic [7:0] d);
    vsw_regs_t w;
    w = r;
    unique case (a)
      VSW_ADDR_FAST:     w.fast = d & VSW_MASK_MODE;
      VSW_ADDR_SIDE:     w.side = d & VSW_MASK_MODE;
      VSW_ADDR_ITERM:    w.iterm = d & VSW_MASK_ITERM;
      VSW_ADDR_PULSE_AB: w.pulse_ab = d & VSW_MASK_FULL;
      VSW_ADDR_PULSE_C:  w.pulse_c = d & VSW_MASK_NIBBLE;
      VSW_ADDR_EQ_AB:    w.eq_ab = d & VSW_MASK_FULL;
      VSW_ADDR_EQ_C:     w.eq_c = d & VSW_MASK_NIBBLE;
      VSW_ADDR_DRV:      w.drv = d & VSW_MASK_DRV;
      default:           w = r;
    endcase
    return w;
  endfunction

  always_comb
  begin
    logic        access;
    logic [1:0]  cur_src;
    logic [11:0] pulse_vec;
    logic [11:0] eq_vec;
    logic        term_on;
    st_nxt = st_r;
    access = reg_wr | reg_rd;
    cur_src = st_r.regs.fast[VSW_SRC_LSB +: 2];
    pulse_vec = {st_r.regs.pulse_c[3:0], st_r.regs.pulse_ab};
    eq_vec = {st_r.regs.eq_c[3:0], st_r.regs.eq_ab};
    term_on = st_r.regs.iterm[VSW_ITERM_BIT];

    // only until the first serial access
    if (!st_r.serial_seen)
    begin
      st_nxt.regs = vsw_strap_image(strap, st_r.regs);
    end

    if (access)
    begin
      st_nxt.serial_seen = 1'b1;
    end

    // Register writes win over the strap image
    if (reg_wr)
    begin
      st_nxt.regs = vsw_write(st_nxt.regs, reg_addr, reg_wdata);
    end

    st_nxt.rvalid = reg_rd;
    if (reg_rd)
    begin
      st_nxt.rdata = vsw_read(st_r.regs, reg_addr);
    end

    st_nxt.prev_src = cur_src;
    pulse_start = (cur_src != st_r.prev_src) && term_on;

    st_nxt.cfg.fast_path_enable = st_r.regs.fast[VSW_ENABLE_BIT];
    st_nxt.cfg.standby = ~st_r.regs.fast[VSW_ENABLE_BIT];
    st_nxt.cfg.fast_source_select = cur_src;

    st_nxt.cfg.side_enable = st_r.regs.side[VSW_ENABLE_BIT];
    st_nxt.cfg.side_source_select = st_r.regs.side[VSW_SRC_LSB +: 2];
    st_nxt.cfg.side_common_port =
      vsw_side_route(st_r.regs.side[VSW_ENABLE_BIT],
                     st_r.regs.side[VSW_SRC_LSB +: 2]);

    st_nxt.cfg.input_termination_on =
      {VSW_CHANNELS{term_on}} & ~(pulse_vec & {VSW_CHANNELS{pulse_busy}});

    st_nxt.cfg.input_eq_select = eq_vec;

    st_nxt.cfg.output_emphasis_level = st_r.regs.drv[VSW_EMPH_LSB +: 2];
    st_nxt.cfg.output_termination_on = st_r.regs.drv[VSW_OTERM_BIT];
    st_nxt.cfg.output_current_level = st_r.regs.drv[VSW_CUR_BIT];

    st_nxt.cfg.strap_mode = ~st_r.serial_seen;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r.regs.fast <= VSW_RST_FAST;
      st_r.regs.side <= VSW_RST_SIDE;
      st_r.regs.iterm <= VSW_RST_ITERM;
      st_r.regs.pulse_ab <= VSW_RST_PULSE_AB;
      st_r.regs.pulse_c <= VSW_RST_PULSE_C;
      st_r.regs.eq_ab <= VSW_RST_EQ_AB;
      st_r.regs.eq_c <= VSW_RST_EQ_C;
      st_r.regs.drv <= VSW_RST_DRV;
      st_r.serial_seen <= 1'b0;
      st_r.prev_src <= VSW_SRC_A;
      st_r.rdata <= 8'h00;
      st_r.rvalid <= 1'b0;
      st_r.cfg.fast_path_enable <= 1'b0;
      st_r.cfg.standby <= 1'b1;
      st_r.cfg.fast_source_select <= VSW_SRC_A;
      st_r.cfg.side_enable <= 1'b0;
      st_r.cfg.side_source_select <= VSW_SRC_A;
      st_r.cfg.side_common_port <= 3'h0;
      st_r.cfg.input_termination_on <= 12'h000;
      st_r.cfg.input_eq_select <= 12'h000;
      st_r.cfg.output_emphasis_level <= 2'h0;
      st_r.cfg.output_termination_on <= 1'b0;
      st_r.cfg.output_current_level <= 1'b0;
      st_r.cfg.strap_mode <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  vsw_pulse_timer #(
    .CYCLES (PULSE_CYCLES),
    .CNT_W  (CNT_W)
  ) u_pulse_timer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (pulse_start),
    .busy  (pulse_busy)
  );

  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign cfg = st_r.cfg;

endmodule // vsw_config_regs
`default_nettype wire

// ===== hdl/vsw_pkg.sv
// Shared constants and carrier types of the video switch configuration bank
package vsw_pkg;

  // Register offsets
  localparam logic [7:0] VSW_ADDR_FAST     = 8'h00;
  localparam logic [7:0] VSW_ADDR_SIDE     = 8'h01;
  localparam logic [7:0] VSW_ADDR_ITERM    = 8'h10;
  localparam logic [7:0] VSW_ADDR_PULSE_AB = 8'h11;
  localparam logic [7:0] VSW_ADDR_PULSE_C  = 8'h12;
  localparam logic [7:0] VSW_ADDR_EQ_AB    = 8'h13;
  localparam logic [7:0] VSW_ADDR_EQ_C     = 8'h14;
  localparam logic [7:0] VSW_ADDR_DRV      = 8'h20;

  // Values after reset
  localparam logic [7:0] VSW_RST_FAST      = 8'h40;
  localparam logic [7:0] VSW_RST_SIDE      = 8'h40;
  localparam logic [7:0] VSW_RST_ITERM     = 8'h01;
  localparam logic [7:0] VSW_RST_PULSE_AB  = 8'h00;
  localparam logic [7:0] VSW_RST_PULSE_C   = 8'h00;
  localparam logic [7:0] VSW_RST_EQ_AB     = 8'h00;
  localparam logic [7:0] VSW_RST_EQ_C      = 8'h00;
  localparam logic [7:0] VSW_RST_DRV       = 8'h03;

  // Writable bits of each register
  localparam logic [7:0] VSW_MASK_MODE     = 8'h43;
  localparam logic [7:0] VSW_MASK_ITERM    = 8'h01;
  localparam logic [7:0] VSW_MASK_FULL     = 8'hFF;
  localparam logic [7:0] VSW_MASK_NIBBLE   = 8'h0F;
  localparam logic [7:0] VSW_MASK_DRV      = 8'h0F;
  localparam logic [7:0] VSW_READ_UNMAPPED = 8'h00;

  // Field positions
  localparam int VSW_ENABLE_BIT    = 6;
  localparam int VSW_SRC_LSB       = 0;
  localparam int VSW_ITERM_BIT     = 0;
  localparam int VSW_CUR_BIT       = 0;
  localparam int VSW_OTERM_BIT     = 1;
  localparam int VSW_EMPH_LSB      = 2;
  localparam int VSW_CHANNELS      = 12;

  // Source codes
  localparam logic [1:0] VSW_SRC_A = 2'h0;
  localparam logic [1:0] VSW_SRC_B = 2'h1;
  localparam logic [1:0] VSW_SRC_C = 2'h2;

  // Termination pulse length
  localparam longint VSW_CLK_HZ       = 40000000;
  localparam longint VSW_PULSE_MS     = 100;
  localparam longint VSW_PULSE_CYCLES =
    (VSW_PULSE_MS * VSW_CLK_HZ + 999) / 1000;

  // Strap pins
  typedef struct packed {
    logic       strap_fast_enable;
    logic [1:0] strap_source_select;
    logic       strap_eq_level;
    logic [1:0] strap_emphasis_pins;
    logic       strap_current_level;
  } vsw_strap_t;

  // Effective configuration towards the analog paths
  typedef struct packed {
    logic        fast_path_enable;
    logic        standby;
    logic [1:0]  fast_source_select;
    logic        side_enable;
    logic [1:0]  side_source_select;
    logic [2:0]  side_common_port;
    logic [11:0] input_termination_on;
    logic [11:0] input_eq_select;
    logic [1:0]  output_emphasis_level;
    logic        output_termination_on;
    logic        output_current_level;
    logic        strap_mode;
  } vsw_cfg_t;

  // Register contents
  typedef struct packed {
    logic [7:0] fast;
    logic [7:0] side;
    logic [7:0] iterm;
    logic [7:0] pulse_ab;
    logic [7:0] pulse_c;
    logic [7:0] eq_ab;
    logic [7:0] eq_c;
    logic [7:0] drv;
  } vsw_regs_t;

endpackage

// ===== hdl/vsw_pulse_timer.sv
// Termination pulse timer, restarted on every fast path source switch made while input termination is on
`timescale 1ns/100ps
`default_nettype none
module vsw_pulse_timer #(
  parameter longint CYCLES = vsw_pkg::VSW_PULSE_CYCLES,
  parameter int     CNT_W  = 22
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  output logic      busy
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } vsw_tmr_state_t;

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);

  vsw_tmr_state_t st_r;
  vsw_tmr_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (start)
    begin
      st_nxt.cnt = LOAD;
    end
    else if (st_r.cnt != '0)
    begin
      st_nxt.cnt = st_r.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign busy = (st_r.cnt != '0);

endmodule // vsw_pulse_timer
`default_nettype wire

// ===== sim/vsw_config_checker_assertions.sv
// Port checker of the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module vsw_config_checker #(
  parameter longint PULSE_CYCLES = 20
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // Register port
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic              reg_rvalid,
  // Straps and configuration
  input wire vsw_pkg::vsw_strap_t strap,
  input wire vsw_pkg::vsw_cfg_t   cfg
);
  import vsw_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_read_answer:
    assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_read_single:
    assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_standby_inverse:
    assert property (cfg.standby == !cfg.fast_path_enable)
    else $error("standby not inverse of enable");
  a_side_routing:
    assert property (cfg.side_common_port == (!cfg.side_enable ? 3'h0 :
      cfg.side_source_select == 2'h3 ? 3'h0 : 3'h1 << cfg.side_source_select))
    else $error("side port routing wrong");
  a_strap_fast:
    assert property (cfg.strap_mode && $past(cfg.strap_mode) |->
      cfg.fast_path_enable == $past(strap.strap_fast_enable, 2) &&
      cfg.fast_source_select == $past(strap.strap_source_select, 2))
    else $error("fast path not following straps");
  a_strap_side:
    assert property (cfg.strap_mode && $past(cfg.strap_mode) |->
      cfg.side_enable && cfg.side_source_select ==
      $past(strap.strap_source_select, 2))
    else $error("side path not following straps");
  a_strap_term:
    assert property (cfg.strap_mode && $past(cfg.strap_mode) |->
      cfg.input_termination_on == 12'hFFF)
    else $error("termination not forced on");
  a_strap_eq:
    assert property (cfg.strap_mode && $past(cfg.strap_mode) |->
      cfg.input_eq_select == {12{$past(strap.strap_eq_level, 2)}})
    else $error("eq pin not replicated");
  a_strap_drv:
    assert property (cfg.strap_mode && $past(cfg.strap_mode) |->
      cfg.output_emphasis_level == $past(strap.strap_emphasis_pins, 2) &&
      cfg.output_current_level == $past(strap.strap_current_level, 2))
    else $error("driver not following straps");
  a_access_ends:
    assert property (reg_wr || reg_rd |-> ##2 !cfg.strap_mode)
    else $error("strap mode kept after access");
endmodule // vsw_config_checker
bind vsw_config_regs vsw_config_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .strap(strap), .cfg(cfg));
`default_nettype wire

// ===== sim/vsw_strap_board.sv
// Board strap pin model: each pin tied high or low
`timescale 1ns/100ps
`default_nettype none
module vsw_strap_board (
  // Board tie levels
  input  wire logic [6:0]       tie,
  // Strap pins
  output vsw_pkg::vsw_strap_t   strap
);
  import vsw_pkg::*;
  assign strap = vsw_strap_t'(tie);
endmodule // vsw_strap_board
`default_nettype wire

// ===== sim/vsw_config_regs_bench.sv
// Self-checking bench of the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module vsw_config_regs_bench;
  import vsw_pkg::*;
  localparam longint PULSE = 20;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v, w;
  logic        mclk, rst_n, reg_wr, reg_rd, reg_rvalid;
  logic [6:0]  tie;
  logic [31:0] seed;
  vsw_strap_t  strap, s0;
  vsw_cfg_t    cfg;
  int          n_mismatch, checked, i;
  logic [7:0]  tbl_addr [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13,
                                8'h14, 8'h20};
  logic [7:0]  tbl_mask [8] = '{8'h43, 8'h43, 8'h01, 8'hFF, 8'h0F, 8'hFF,
                                8'h0F, 8'h0F};

  vsw_strap_board board (.tie(tie), .strap(strap));
  vsw_config_regs #(.PULSE_CYCLES(PULSE)) dut (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .strap(strap), .cfg(cfg));

  always #12.5 mclk = ~mclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Register image loaded from straps
  function automatic logic [7:0] img(input logic [7:0] a, input vsw_strap_t s);
    case (a)
      8'h00: img = {1'b0, s.strap_fast_enable, 4'h0, s.strap_source_select};
      8'h01: img = {6'h10, s.strap_source_select};
      8'h10: img = 8'h01;
      8'h13: img = {8{s.strap_eq_level}};
      8'h14: img = {4'h0, {4{s.strap_eq_level}}};
      8'h20: img = {4'h0, s.strap_emphasis_pins, 1'b1, s.strap_current_level};
      default: img = 8'h00;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rvalid, 1'b1);
    check(reg_rdata, e);
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    {mclk, rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, tie} = '0;
    {n_mismatch, checked} = '0;
    seed = 32'hDE1A;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      @(posedge mclk);
      tie <= {seed[6], seed[5:4] == 2'h3 ? 2'h2 : seed[5:4], seed[3:0]};
      tick(3);
      check(cfg.fast_source_select, strap.strap_source_select);
      check(cfg.fast_path_enable, strap.strap_fast_enable);
      check(cfg.side_common_port, 3'h1 << strap.strap_source_select);
      check(cfg.output_current_level, strap.strap_current_level);
      check(cfg.input_termination_on, 12'hFFF);
      check(cfg.input_eq_select, {12{strap.strap_eq_level}});
      check(cfg.output_emphasis_level, strap.strap_emphasis_pins);
    end
    s0 = strap;
    for (i = 0; i < 8; i++)
      rd(tbl_addr[i], img(tbl_addr[i], s0));
    @(posedge mclk);
    tie <= ~tie & 7'h5F;
    tick(3);
    check(cfg.input_eq_select, {12{s0.strap_eq_level}});
    for (i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      w = seed[7:0];
      if (i < 2 && w[1:0] == 2'h3)
        w[1] = 1'b0;
      wr(tbl_addr[i], w);
      rd(tbl_addr[i], w & tbl_mask[i]);
    end
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    for (i = 0; i < 3; i++)
    begin
      wr(8'h01, 8'h40 | i[7:0]);
      tick(2);
      check(cfg.side_common_port, 3'h1 << i);
    end
    wr(8'h01, 8'h02);
    tick(2);
    check(cfg.side_common_port, 3'h0);
    wr(8'h00, 8'h01);
    tick(2);
    check({cfg.fast_path_enable, cfg.standby}, 2'h1);
    wr(8'h00, 8'h40);
    tick(2);
    check({cfg.fast_path_enable, cfg.standby}, 2'h2);
    for (i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      w = {4'h0, i[1:0], seed[1:0]};
      wr(8'h20, w);
      tick(2);
      check(cfg.output_emphasis_level, i[1:0]);
      check(cfg.output_termination_on, w[1]);
      check(cfg.output_current_level, w[0]);
    end
    seed = xs(seed);
    v = seed[7:0];
    w = seed[15:8];
    wr(8'h13, v);
    wr(8'h14, w);
    tick(2);
    check(cfg.input_eq_select, {w[3:0], v});
    w[0] = 1'b1;
    v[3] = 1'b0;
    wr(8'h10, 8'h01);
    wr(8'h11, w);
    wr(8'h12, v);
    tick(int'(PULSE) + 5);
    check(cfg.input_termination_on, 12'hFFF);
    wr(8'h00, 8'h42);
    tick(2);
    check(cfg.input_termination_on, {v[3:0], w} ^ 12'hFFF);
    tick(int'(PULSE) - 1);
    check(cfg.input_termination_on, {v[3:0], w} ^ 12'hFFF);
    tick(1);
    check(cfg.input_termination_on, 12'hFFF);
    wr(8'h10, 8'h00);
    tick(2);
    check(cfg.input_termination_on, 12'h000);
    // Mid-run reset brings strap mode back
    @(posedge mclk);
    rst_n <= 1'b0;
    tie <= 7'h5F;
    tick(2);
    check({cfg.fast_path_enable, cfg.standby}, 2'h1);
    @(posedge mclk);
    rst_n <= 1'b1;
    tick(3);
    check(cfg.strap_mode, 1'b1);
    check(cfg.fast_source_select, 2'h1);
    check(cfg.input_eq_select, 12'hFFF);
    test_done();
  end
endmodule // vsw_config_regs_bench
`default_nettype wire
